/* File: inc/dsdpr_consts.svh */
`ifndef DSDPR_CONSTS_SVH
`define DSDPR_CONSTS_SVH

// Serial word layout, positions in the 22-bit shift register
`define DSDPR_WORD_W 22
`define DSDPR_DATA_W 20
`define DSDPR_ADDR_LSB 0
`define DSDPR_DATA_LSB 2
// Reference word fields
`define DSDPR_R_CNT_LSB 2
`define DSDPR_R_CNT_MSB 16
`define DSDPR_R_POL_BIT 17
`define DSDPR_R_HICUR_BIT 18
`define DSDPR_R_HIZ_BIT 19
`define DSDPR_R_SEL_LO_BIT 20
`define DSDPR_R_SEL_HI_BIT 21
// Feedback word fields
`define DSDPR_N_A_LSB 2
`define DSDPR_N_A_MSB 6
`define DSDPR_N_B_LSB 7
`define DSDPR_N_B_MSB 19
`define DSDPR_N_PRESC_BIT 20
`define DSDPR_N_SLEEP_BIT 21
// Reset value of every latched data word
`define DSDPR_WORD_RESET 20'h00000
// Least high or low time of the link clock, in ns
`define DSDPR_LINK_MIN_NS 50
`define DSDPR_CLK_NS 100

`endif

/* File: inc/dsdpr_pkg.sv */
package dsdpr_pkg;
  typedef enum logic [1:0] {
    DSDPR_SEL_SEC_REF = 2'h0,
    DSDPR_SEL_SEC_FB = 2'h1,
    DSDPR_SEL_PRI_REF = 2'h2,
    DSDPR_SEL_PRI_FB = 2'h3
  } dsdpr_sel_t;
  typedef logic [19:0] dsdpr_data_t;
endpackage

/* File: hw/dsdpr_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module dsdpr_sync (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic async_in,
  output logic sync_out,
  output logic rise_pulse
);
  logic meta_r;
  logic sync_r;
  logic last_r;
  logic meta_nxt;
  logic sync_nxt;
  logic last_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
    last_nxt = sync_r;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
    end
  end

  assign sync_out = sync_r;
  assign rise_pulse = sync_r & ~last_r;
endmodule
`default_nettype wire

/* File: hw/dsdpr_loop_counter.sv */
`timescale 1ns/1ps
`default_nettype none
// Free-running divider held at zero while its loop sleeps
module dsdpr_loop_counter #(
  parameter int WIDTH = 15
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic count_en,
  input wire logic hold_zero,
  input wire logic [WIDTH-1:0] ratio,
  output logic [WIDTH-1:0] count,
  output logic wrap_pulse
);
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic wrap_r;
  logic wrap_nxt;

  initial begin
    if (WIDTH < 2 || WIDTH > 24) $error("dsdpr_loop_counter: WIDTH out of range");
  end

  always_comb begin
    count_nxt = count_r;
    wrap_nxt = 1'b0;
    if (hold_zero) begin
      count_nxt = '0;
    end else if (count_en) begin
      if (count_r + WIDTH'(1) >= ratio) begin
        count_nxt = '0;
        wrap_nxt = 1'b1;
      end else begin
        count_nxt = count_r + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      count_r <= '0;
      wrap_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      wrap_r <= wrap_nxt;
    end
  end

  assign count = count_r;
  assign wrap_pulse = wrap_r;
endmodule
`default_nettype wire

/* File: hw/dsdpr_regs.sv */
// Function
// [RULE_01] Address 00 latches secondary reference word
// [RULE_02] Address 10 latches primary reference word
// [RULE_03] Address 01 latches secondary feedback word
// [RULE_04] Address 11 latches primary feedback word
// [RULE_05] Controller shifts MSB first, address last
// [RULE_06] Reference ratio in bits 16..2 sets counter
// [RULE_07] Controller keeps reference ratio 2..32767
// [RULE_08] Secondary reference word carries mode bits 21..17
// [RULE_09] Primary reference word carries mode bits 21..17
// [RULE_10] Secondary feedback: swallow 6..2, program 19..7
// [RULE_11] Primary feedback: swallow 6..2, program 19..7
// [RULE_12] Secondary sleep bit 21, prescaler bit 20
// [RULE_13] Primary sleep bit 21, prescaler bit 20
// [RULE_14] Controller keeps program count 3..8191
// [RULE_15] Prescaler bit 0 low pair, 1 high pair
// [RULE_16] Controller keeps swallow below modulus and program; the test controller also writes swallow equal to program
// [RULE_17] Sleeping loop counters held zero, restart zero
// [RULE_18] Data sampled on link clock rise, strobe low
`timescale 1ns/1ps
`default_nettype none
`include "dsdpr_consts.svh"
module dsdpr_regs #(
  parameter int REF_W = 15,
  parameter int PROG_W = 13,
  parameter int SWAL_W = 5
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic link_data,
  input wire logic link_clock,
  input wire logic latch_strobe,
  input wire logic secondary_ref_tick,
  input wire logic primary_ref_tick,
  input wire logic secondary_fb_tick,
  input wire logic primary_fb_tick,
  output dsdpr_pkg::dsdpr_data_t secondary_ref_divider_word,
  output dsdpr_pkg::dsdpr_data_t primary_ref_divider_word,
  output dsdpr_pkg::dsdpr_data_t secondary_feedback_divider_word,
  output dsdpr_pkg::dsdpr_data_t primary_feedback_divider_word,
  output logic [REF_W-1:0] secondary_ref_count,
  output logic [REF_W-1:0] primary_ref_count,
  output logic [SWAL_W-1:0] secondary_swallow_count,
  output logic [PROG_W-1:0] secondary_prog_count,
  output logic [SWAL_W-1:0] primary_swallow_count,
  output logic [PROG_W-1:0] primary_prog_count,
  output logic [3:0] test_output_select,
  output logic secondary_pump_hiz,
  output logic primary_pump_hiz,
  output logic secondary_pump_high_current,
  output logic primary_pump_high_current,
  output logic secondary_detector_polarity,
  output logic primary_detector_polarity,
  output logic secondary_loop_sleep,
  output logic primary_loop_sleep,
  output logic [5:0] secondary_modulus,
  output logic [5:0] primary_modulus,
  output logic secondary_ref_wrap,
  output logic primary_ref_wrap,
  output logic secondary_fb_wrap,
  output logic primary_fb_wrap
);
  import dsdpr_pkg::*;

  localparam int LINK_MIN_CYC = (`DSDPR_LINK_MIN_NS + `DSDPR_CLK_NS - 1) / `DSDPR_CLK_NS;
  localparam int FB_W = PROG_W + SWAL_W;

  initial begin
    if (REF_W != `DSDPR_R_CNT_MSB - `DSDPR_R_CNT_LSB + 1) $error("dsdpr_regs: REF_W mismatch");
    if (PROG_W != `DSDPR_N_B_MSB - `DSDPR_N_B_LSB + 1) $error("dsdpr_regs: PROG_W mismatch");
    if (SWAL_W != `DSDPR_N_A_MSB - `DSDPR_N_A_LSB + 1) $error("dsdpr_regs: SWAL_W mismatch");
    if (LINK_MIN_CYC < 1) $error("dsdpr_regs: link timing too short");
    if (`DSDPR_DATA_W + 2 != `DSDPR_WORD_W) $error("dsdpr_regs: word layout mismatch");
    if (FB_W > 24) $error("dsdpr_regs: feedback counter too wide");
    if ((1 << SWAL_W) != 32) $error("dsdpr_regs: swallow width must match high modulus");
  end

  // Low modulus of the dual-modulus prescaler for each select level
  function automatic logic [5:0] modulus_of(input logic presc_high);
    modulus_of = presc_high ? 6'h20 : 6'h10;
  endfunction

  // A word keeps its value unless this strobe edge addressed it
  function automatic dsdpr_data_t next_word(
    input dsdpr_data_t cur,
    input logic hit,
    input dsdpr_data_t fresh
  );
    next_word = hit ? fresh : cur;
  endfunction

  // Feedback ratio is program count times modulus plus swallow count
  function automatic logic [FB_W-1:0] fb_ratio_of(
    input logic [PROG_W-1:0] prog,
    input logic [SWAL_W-1:0] swallow,
    input logic [5:0] modulus
  );
    logic [FB_W-1:0] scaled;
    scaled = {prog, {SWAL_W{1'b0}}};
    if (modulus == 6'h10) begin
      scaled = scaled >> 1;
    end
    fb_ratio_of = scaled + FB_W'(swallow);
  endfunction

  logic clk_sync;
  logic clk_rise;
  logic data_sync;
  logic strobe_sync;
  logic strobe_rise;

  // Data is delayed by the same two stages as the clock so both line up
  dsdpr_sync u_sync_clk (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(link_clock),
    .sync_out(clk_sync),
    .rise_pulse(clk_rise)
  );

  dsdpr_sync u_sync_data (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(link_data),
    .sync_out(data_sync),
    .rise_pulse()
  );

  dsdpr_sync u_sync_strobe (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(latch_strobe),
    .sync_out(strobe_sync),
    .rise_pulse(strobe_rise)
  );

  logic [`DSDPR_WORD_W-1:0] shift_r;
  logic [`DSDPR_WORD_W-1:0] shift_nxt;
  dsdpr_data_t sec_ref_r;
  dsdpr_data_t sec_ref_nxt;
  dsdpr_data_t pri_ref_r;
  dsdpr_data_t pri_ref_nxt;
  dsdpr_data_t sec_fb_r;
  dsdpr_data_t sec_fb_nxt;
  dsdpr_data_t pri_fb_r;
  dsdpr_data_t pri_fb_nxt;
  dsdpr_sel_t sel;
  dsdpr_data_t data_field;
  logic [3:0] load_hit;

  assign sel = dsdpr_sel_t'(shift_r[`DSDPR_ADDR_LSB +: 2]);
  assign data_field = shift_r[`DSDPR_DATA_LSB +: `DSDPR_DATA_W];

  always_comb begin
    shift_nxt = shift_r;
    // Serial clock edges while the strobe is high are ignored
    if (clk_rise && !strobe_sync) begin
      shift_nxt = {shift_r[`DSDPR_WORD_W-2:0], data_sync}; // see [RULE_18] see [RULE_05]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      shift_r <= '0;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // Bit index of load_hit equals the address code
  always_comb begin
    load_hit = 4'h0;
    if (strobe_rise) begin
      unique case (sel)
        DSDPR_SEL_SEC_REF: load_hit[0] = 1'b1; // see [RULE_01]
        DSDPR_SEL_SEC_FB: load_hit[1] = 1'b1; // see [RULE_03]
        DSDPR_SEL_PRI_REF: load_hit[2] = 1'b1; // see [RULE_02]
        DSDPR_SEL_PRI_FB: load_hit[3] = 1'b1; // see [RULE_04]
      endcase
    end
  end

  always_comb begin
    sec_ref_nxt = next_word(sec_ref_r, load_hit[0], data_field); // see [RULE_01]
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sec_ref_r <= `DSDPR_WORD_RESET;
    end else begin
      sec_ref_r <= sec_ref_nxt;
    end
  end

  always_comb begin
    sec_fb_nxt = next_word(sec_fb_r, load_hit[1], data_field); // see [RULE_03]
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sec_fb_r <= `DSDPR_WORD_RESET;
    end else begin
      sec_fb_r <= sec_fb_nxt;
    end
  end

  always_comb begin
    pri_ref_nxt = next_word(pri_ref_r, load_hit[2], data_field); // see [RULE_02]
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pri_ref_r <= `DSDPR_WORD_RESET;
    end else begin
      pri_ref_r <= pri_ref_nxt;
    end
  end

  always_comb begin
    pri_fb_nxt = next_word(pri_fb_r, load_hit[3], data_field); // see [RULE_04]
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pri_fb_r <= `DSDPR_WORD_RESET;
    end else begin
      pri_fb_r <= pri_fb_nxt;
    end
  end

  assign secondary_ref_divider_word = sec_ref_r;
  assign primary_ref_divider_word = pri_ref_r;
  assign secondary_feedback_divider_word = sec_fb_r;
  assign primary_feedback_divider_word = pri_fb_r;

  // Data words hold shift positions 21..2, so subtract the data offset
  localparam int D = `DSDPR_DATA_LSB;
  assign secondary_ref_count = sec_ref_r[`DSDPR_R_CNT_MSB-D:`DSDPR_R_CNT_LSB-D]; // see [RULE_06]
  assign primary_ref_count = pri_ref_r[`DSDPR_R_CNT_MSB-D:`DSDPR_R_CNT_LSB-D]; // see [RULE_06]
  assign test_output_select = {
    pri_ref_r[`DSDPR_R_SEL_HI_BIT-D],
    pri_ref_r[`DSDPR_R_SEL_LO_BIT-D],
    sec_ref_r[`DSDPR_R_SEL_HI_BIT-D],
    sec_ref_r[`DSDPR_R_SEL_LO_BIT-D]
  }; // see [RULE_08] see [RULE_09]
  assign secondary_pump_hiz = sec_ref_r[`DSDPR_R_HIZ_BIT-D]; // see [RULE_08]
  assign secondary_pump_high_current = sec_ref_r[`DSDPR_R_HICUR_BIT-D]; // see [RULE_08]
  assign secondary_detector_polarity = sec_ref_r[`DSDPR_R_POL_BIT-D]; // see [RULE_08]
  assign primary_pump_hiz = pri_ref_r[`DSDPR_R_HIZ_BIT-D]; // see [RULE_09]
  assign primary_pump_high_current = pri_ref_r[`DSDPR_R_HICUR_BIT-D]; // see [RULE_09]
  assign primary_detector_polarity = pri_ref_r[`DSDPR_R_POL_BIT-D]; // see [RULE_09]
  assign secondary_swallow_count = sec_fb_r[`DSDPR_N_A_MSB-D:`DSDPR_N_A_LSB-D]; // see [RULE_10]
  assign secondary_prog_count = sec_fb_r[`DSDPR_N_B_MSB-D:`DSDPR_N_B_LSB-D]; // see [RULE_10]
  assign primary_swallow_count = pri_fb_r[`DSDPR_N_A_MSB-D:`DSDPR_N_A_LSB-D]; // see [RULE_11]
  assign primary_prog_count = pri_fb_r[`DSDPR_N_B_MSB-D:`DSDPR_N_B_LSB-D]; // see [RULE_11]
  assign secondary_loop_sleep = sec_fb_r[`DSDPR_N_SLEEP_BIT-D]; // see [RULE_12]
  assign primary_loop_sleep = pri_fb_r[`DSDPR_N_SLEEP_BIT-D]; // see [RULE_13]
  // Only the 16/32 band is modelled; the lowest-band loop halves this value
  assign secondary_modulus = modulus_of(sec_fb_r[`DSDPR_N_PRESC_BIT-D]); // see [RULE_12] see [RULE_15]
  assign primary_modulus = modulus_of(pri_fb_r[`DSDPR_N_PRESC_BIT-D]); // see [RULE_13] see [RULE_15]

  logic [FB_W-1:0] sec_fb_ratio;
  logic [FB_W-1:0] pri_fb_ratio;
  assign sec_fb_ratio = fb_ratio_of(secondary_prog_count, secondary_swallow_count, secondary_modulus);
  assign pri_fb_ratio = fb_ratio_of(primary_prog_count, primary_swallow_count, primary_modulus);

  dsdpr_loop_counter #(.WIDTH(REF_W)) u_sec_ref_cnt (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .count_en(secondary_ref_tick),
    .hold_zero(secondary_loop_sleep), // see [RULE_17]
    .ratio(secondary_ref_count),
    .count(),
    .wrap_pulse(secondary_ref_wrap)
  );

  dsdpr_loop_counter #(.WIDTH(REF_W)) u_pri_ref_cnt (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .count_en(primary_ref_tick),
    .hold_zero(primary_loop_sleep), // see [RULE_17]
    .ratio(primary_ref_count),
    .count(),
    .wrap_pulse(primary_ref_wrap)
  );

  dsdpr_loop_counter #(.WIDTH(FB_W)) u_sec_fb_cnt (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .count_en(secondary_fb_tick),
    .hold_zero(secondary_loop_sleep), // see [RULE_17]
    .ratio(sec_fb_ratio),
    .count(),
    .wrap_pulse(secondary_fb_wrap)
  );

  dsdpr_loop_counter #(.WIDTH(FB_W)) u_pri_fb_cnt (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .count_en(primary_fb_tick),
    .hold_zero(primary_loop_sleep), // see [RULE_17]
    .ratio(pri_fb_ratio),
    .count(),
    .wrap_pulse(primary_fb_wrap)
  );
endmodule
`default_nettype wire

/* File: test/dsdpr_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module dsdpr_regs_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic latch_strobe,
  input wire dsdpr_pkg::dsdpr_data_t secondary_ref_divider_word,
  input wire dsdpr_pkg::dsdpr_data_t primary_ref_divider_word,
  input wire dsdpr_pkg::dsdpr_data_t secondary_feedback_divider_word,
  input wire dsdpr_pkg::dsdpr_data_t primary_feedback_divider_word,
  input wire logic [14:0] secondary_ref_count,
  input wire logic [14:0] primary_ref_count,
  input wire logic [4:0] secondary_swallow_count,
  input wire logic [12:0] secondary_prog_count,
  input wire logic [4:0] primary_swallow_count,
  input wire logic [12:0] primary_prog_count,
  input wire logic [3:0] test_output_select,
  input wire logic secondary_pump_hiz,
  input wire logic primary_pump_hiz,
  input wire logic secondary_pump_high_current,
  input wire logic primary_pump_high_current,
  input wire logic secondary_detector_polarity,
  input wire logic primary_detector_polarity,
  input wire logic secondary_loop_sleep,
  input wire logic primary_loop_sleep,
  input wire logic [5:0] secondary_modulus,
  input wire logic [5:0] primary_modulus,
  input wire logic secondary_ref_wrap,
  input wire logic primary_ref_wrap,
  input wire logic secondary_fb_wrap,
  input wire logic primary_fb_wrap
);
  import dsdpr_pkg::*;
  dsdpr_data_t sr, pr, sf, pf;
  logic [2:0] quiet_r, quiet_nxt;
  assign sr = secondary_ref_divider_word;
  assign pr = primary_ref_divider_word;
  assign sf = secondary_feedback_divider_word;
  assign pf = primary_feedback_divider_word;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Strobe-low cycles, saturating; the synchronisers need a few cycles before words may be frozen
  always_comb begin
    quiet_nxt = latch_strobe ? 3'h0 : ((quiet_r == 3'h7) ? quiet_r : quiet_r + 3'h1);
  end
  always_ff @(posedge clk_sys) begin
    quiet_r <= reset_n ? quiet_nxt : 3'h0;
  end
  sequence s_sec_asleep;
    secondary_loop_sleep [*3];
  endsequence
  sequence s_pri_asleep;
    primary_loop_sleep [*3];
  endsequence
  a_sec_ref_fields: assert property (
    secondary_ref_count == sr[14:0] && secondary_detector_polarity == sr[15]
    && secondary_pump_high_current == sr[16] && secondary_pump_hiz == sr[17])
    else $error("secondary reference fields differ from word");
  a_pri_ref_fields: assert property (
    primary_ref_count == pr[14:0] && primary_detector_polarity == pr[15]
    && primary_pump_high_current == pr[16] && primary_pump_hiz == pr[17])
    else $error("primary reference fields differ from word");
  a_output_select: assert property (test_output_select == {pr[19:18], sr[19:18]})
    else $error("output select differs from reference words");
  a_sec_fb_fields: assert property (
    secondary_swallow_count == sf[4:0] && secondary_prog_count == sf[17:5] && secondary_loop_sleep == sf[19])
    else $error("secondary feedback fields differ from word");
  a_pri_fb_fields: assert property (
    primary_swallow_count == pf[4:0] && primary_prog_count == pf[17:5] && primary_loop_sleep == pf[19])
    else $error("primary feedback fields differ from word");
  a_modulus_map: assert property (
    secondary_modulus == (sf[18] ? 6'h20 : 6'h10) && primary_modulus == (pf[18] ? 6'h20 : 6'h10))
    else $error("prescaler modulus does not follow select bit");
  a_words_hold: assert property (
    quiet_r >= 3'h3 |-> $stable({sr, pr, sf, pf}))
    else $error("word changed without a strobe");
  a_sec_sleep_idle: assert property (s_sec_asleep |-> !secondary_ref_wrap && !secondary_fb_wrap)
    else $error("secondary counters run while asleep");
  a_pri_sleep_idle: assert property (s_pri_asleep |-> !primary_ref_wrap && !primary_fb_wrap)
    else $error("primary counters run while asleep");
endmodule
`default_nettype wire

/* File: test/dsdpr_link_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module dsdpr_link_ctl (
  input wire logic clk_sys,
  output logic link_data,
  output logic link_clock,
  output logic latch_strobe
);
  initial begin
    link_data = 1'b0;
    link_clock = 1'b0;
    latch_strobe = 1'b0;
  end
  // Link clock idles low between frames; junk pulses arrive while the strobe is up
  task automatic frame(input logic [31:0] v, input int n, input int junk);
    for (int i = n - 1; i >= 0; i--) begin
      link_data <= v[i];
      repeat (4) @(posedge clk_sys);
      link_clock <= 1'b1;
      repeat (4) @(posedge clk_sys);
      link_clock <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    latch_strobe <= 1'b1;
    link_data <= ~link_data;
    for (int j = 0; j < junk; j++) begin
      repeat (2) @(posedge clk_sys);
      link_clock <= 1'b1;
      repeat (2) @(posedge clk_sys);
      link_clock <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
    latch_strobe <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

/* File: test/dual_synth_divider_program_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module dual_synth_divider_program_regs_test;
  import dsdpr_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] tick = 4'h0;
  logic link_data, link_clock, latch_strobe;
  dsdpr_data_t word [4];
  dsdpr_data_t prev [4] = '{4{20'h00000}};
  dsdpr_data_t shadow [4] = '{4{20'h00000}};
  logic [21:0] sr = 22'h000000;
  logic [21:0] note;
  logic [21:0] q [$];
  int n_mismatch = 0;
  int total_checks = 0;
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) tick <= 4'($urandom);
  dsdpr_link_ctl i_dsdpr_link_ctl (.clk_sys(clk_sys), .link_data(link_data), .link_clock(link_clock),
    .latch_strobe(latch_strobe));
  dsdpr_regs i_dsdpr_regs (.clk_sys(clk_sys), .reset_n(reset_n), .link_data(link_data),
    .link_clock(link_clock), .latch_strobe(latch_strobe), .secondary_ref_tick(tick[0]),
    .primary_ref_tick(tick[1]), .secondary_fb_tick(tick[2]), .primary_fb_tick(tick[3]),
    .secondary_ref_divider_word(word[0]), .secondary_feedback_divider_word(word[1]),
    .primary_ref_divider_word(word[2]), .primary_feedback_divider_word(word[3]),
    .secondary_ref_count(), .primary_ref_count(), .secondary_swallow_count(), .secondary_prog_count(),
    .primary_swallow_count(), .primary_prog_count(), .test_output_select(), .secondary_pump_hiz(),
    .primary_pump_hiz(), .secondary_pump_high_current(), .primary_pump_high_current(),
    .secondary_detector_polarity(), .primary_detector_polarity(), .secondary_loop_sleep(),
    .primary_loop_sleep(), .secondary_modulus(), .primary_modulus(), .secondary_ref_wrap(),
    .primary_ref_wrap(), .secondary_fb_wrap(), .primary_fb_wrap());
  // Word index equals the address field, so a change in word k must match the oldest note
  always @(posedge clk_sys) begin
    for (int k = 0; k < 4; k++) begin
      if (reset_n && word[k] !== prev[k]) begin
        note = (q.size() > 0) ? q.pop_front() : 22'hX;
        `CHK({word[k], 2'(k)}, note)
      end
      prev[k] = word[k];
    end
  end
  function automatic logic [21:0] legal(input logic [1:0] a);
    logic [12:0] b;
    logic [4:0] s;
    b = 13'(3 + $urandom % 8189);
    s = 5'($urandom % 16);
    if (s > b[4:0] && b < 13'h0020) s = b[4:0];
    if (a[0]) return {2'($urandom), b, s, a};
    return {5'($urandom), 15'(2 + $urandom % 32766), a};
  endfunction
  task automatic wr(input logic [31:0] v, input int n, input int junk);
    for (int i = n - 1; i >= 0; i--) sr = {sr[20:0], v[i]};
    if (shadow[sr[1:0]] !== sr[21:2]) q.push_back(sr);
    shadow[sr[1:0]] = sr[21:2];
    i_dsdpr_link_ctl.frame(v, n, junk);
    repeat (40) @(posedge clk_sys);
  endtask
  task automatic close_out();
    `CHK(32'(q.size()), 32'h0)
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    void'($urandom(79920));
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int k = 0; k < 4; k++) `CHK(word[k], 20'h00000) // reset value
    for (int r = 0; r < 12; r++) wr(32'(legal(2'(r))), 22, 0);
    // Leading extra bits must fall out of the far end
    wr({10'h3FF, legal(2'h2)}, 32, 0);
    // Link clock pulses under a raised strobe must not shift; the short frame exposes them
    wr(32'(legal(2'h1)), 22, 3);
    wr(32'h00002A0B, 14, 0);
    wr(32'({5'h00, 15'h0002, 2'h0}), 22, 0);
    wr(32'({5'h1F, 15'h7FFF, 2'h2}), 22, 0);
    wr(32'({2'h1, 13'h1FFF, 5'h1F, 2'h3}), 22, 0);
    wr(32'({2'h2, 13'h0003, 5'h03, 2'h1}), 22, 0);
    close_out();
  end
  initial begin
    #2ms;
    n_mismatch++;
    close_out();
  end
endmodule
bind dsdpr_regs dsdpr_regs_chk i_dsdpr_regs_chk (.clk_sys, .reset_n, .latch_strobe, .secondary_ref_divider_word,
  .primary_ref_divider_word, .secondary_feedback_divider_word, .primary_feedback_divider_word,
  .secondary_ref_count, .primary_ref_count, .secondary_swallow_count, .secondary_prog_count,
  .primary_swallow_count, .primary_prog_count, .test_output_select, .secondary_pump_hiz, .primary_pump_hiz,
  .secondary_pump_high_current, .primary_pump_high_current, .secondary_detector_polarity,
  .primary_detector_polarity, .secondary_loop_sleep, .primary_loop_sleep, .secondary_modulus,
  .primary_modulus, .secondary_ref_wrap, .primary_ref_wrap, .secondary_fb_wrap, .primary_fb_wrap);
`default_nettype wire
